// file: hw/adc_serial_command_decoder.sv
// Purpose: serial command decoder, result readout and settings registers
// Assumes: serial pins asynchronous to clk_sys, serial clock well below 50 MHz
// Notes: converter core sits outside; results enter through an 8-word fifo
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// result fifo
// ------------------------------------------------------------
module adc_result_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic flush,
   // fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
   localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_q;
   logic [AW-1:0] rdPtr_q;
   logic [AW:0] count_q;
   logic full_q;
   logic empty_q;
   // ready comes from its own flop so the top output is registered
   logic notFull_q;

   wire logic doWrite = inValid & ~full_q;
   wire logic doRead = outReady & ~empty_q;
   wire logic [AW:0] countNext = count_q + (AW + 1)'(doWrite) - (AW + 1)'(doRead);

   assign inReady = notFull_q;
   assign outValid = ~empty_q;
   assign outData = mem[rdPtr_q];

   always_ff @(posedge clk_sys) begin
      if (doWrite) begin
         mem[wrPtr_q] <= inData;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
         full_q <= 1'b0;
         notFull_q <= 1'b1;
         empty_q <= 1'b1;
      end else if (flush) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
         full_q <= 1'b0;
         notFull_q <= 1'b1;
         empty_q <= 1'b1;
      end else begin
         if (doWrite) begin
            wrPtr_q <= (wrPtr_q == LAST_PTR) ? '0 : wrPtr_q + AW'(1);
         end
         if (doRead) begin
            rdPtr_q <= (rdPtr_q == LAST_PTR) ? '0 : rdPtr_q + AW'(1);
         end
         count_q <= countNext;
         full_q <= (countNext == FULL_COUNT);
         notFull_q <= (countNext != FULL_COUNT);
         empty_q <= (countNext == '0);
      end
   end
endmodule

// ------------------------------------------------------------
// top
// ------------------------------------------------------------
module adc_serial_command_decoder #(
   parameter int FIFO_DEPTH = adc_cmd_pkg::FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // serial pins
   input wire logic serialClk,
   input wire logic chipSelectN,
   input wire logic serialIn,
   output logic serialOutWithReady,
   output logic serialOutEnN,
   output logic resultReadyN,
   // converter core
   input wire logic convResultValid,
   output logic convResultReady,
   input wire logic [adc_cmd_pkg::RESULT_W-1:0] convResult,
   output logic convRestart,
   output logic coreReset,
   output logic sleepMode,
   // settings towards the analog side
   output adc_cmd_pkg::cfg_s cfgOut,
   output logic [3:0] inputSelect,
   output logic inputActive,
   output logic [7:0] gainValue,
   output logic ampBypass,
   output logic convContinuous,
   output logic lowSideSwitchCtrl,
   output logic [2:0] excitationSource
);
   localparam int RW = adc_cmd_pkg::RESULT_W;

   function automatic logic opMatch(input logic [7:0] b, input logic [7:0] code,
                                    input logic [7:0] mask);
      opMatch = ((b & mask) == code);
   endfunction

   // register bytes from rr upward, left-justified, wrapping past the last one
   function automatic logic [31:0] regWindow(input logic [3:0][7:0] regs,
                                             input logic [1:0] rr);
      logic [1:0] idx;
      regWindow = '0;
      for (int i = 0; i < adc_cmd_pkg::NUM_REGS; i++) begin
         idx = rr + 2'(i);
         regWindow[31-8*i -: 8] = regs[idx];
      end
   endfunction

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [2:0] sclkSync_q;
   logic [2:0] csSync_q;
   logic [2:0] dinSync_q;
   logic sclkF_q;
   logic csFiltN_q;

   // a change counts once stages two and three agree
   wire logic sclkNext = (sclkSync_q[1] == sclkSync_q[2]) ? sclkSync_q[2] : sclkF_q;
   wire logic csNextN = (csSync_q[1] == csSync_q[2]) ? csSync_q[2] : csFiltN_q;
   wire logic dinAgree = (dinSync_q[1] == dinSync_q[2]);
   wire logic dinBit = dinSync_q[2];
   wire logic active = ~csFiltN_q & ~csNextN;
   wire logic sclkRise = sclkNext & ~sclkF_q;
   wire logic sclkFall = ~sclkNext & sclkF_q;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sclkSync_q <= '0;
         csSync_q <= 3'h7;
         dinSync_q <= '0;
         sclkF_q <= 1'b0;
         csFiltN_q <= 1'b1;
      end else begin
         sclkSync_q <= {sclkSync_q[1:0], serialClk};
         csSync_q <= {csSync_q[1:0], chipSelectN};
         dinSync_q <= {dinSync_q[1:0], serialIn};
         sclkF_q <= sclkNext;
         csFiltN_q <= csNextN;
      end
   end

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   adc_cmd_pkg::cmd_state_e state_q;
   logic [3:0][7:0] cfgQ;
   logic [3:0][7:0] stage_q;
   logic [1:0] wrIdx_q;
   logic [1:0] wrLeft_q;
   logic [2:0] bitCnt_q;
   logic [7:0] rxShift_q;
   logic dinHeld_q;
   logic [31:0] txShift_q;
   logic [2:0] txBytes_q;
   logic dataBit_q;
   logic [RW-1:0] resultBuf_q;
   logic readyN_q;
   logic sleep_q;
   logic restart_q;
   logic coreReset_q;
   logic outEnN_q;
   logic serialOut_q;
   logic [3:0] inSel_q;
   logic inAct_q;
   logic [7:0] gain_q;
   logic bypass_q;
   logic contMode_q;
   logic switch_q;
   logic [2:0] exc_q;

   // data input latched on falling edges only
   wire logic dinSample = dinAgree ? dinBit : dinHeld_q;
   wire logic [7:0] rxByte = {rxShift_q[6:0], dinSample};
   wire logic byteDone = active & sclkFall & (bitCnt_q == adc_cmd_pkg::LAST_BIT);
   wire logic opByte = byteDone & (state_q == adc_cmd_pkg::CMD_OPCODE);
   wire logic wrByte = byteDone & (state_q == adc_cmd_pkg::CMD_WDATA);
   wire logic isReset = opByte & opMatch(rxByte, adc_cmd_pkg::OP_RESET,
                                         adc_cmd_pkg::MASK_LSB_FREE);
   wire logic isKick = opByte & opMatch(rxByte, adc_cmd_pkg::OP_KICK,
                                        adc_cmd_pkg::MASK_LSB_FREE);
   wire logic isSleep = opByte & opMatch(rxByte, adc_cmd_pkg::OP_SLEEP,
                                         adc_cmd_pkg::MASK_LSB_FREE);
   wire logic isFetch = opByte & opMatch(rxByte, adc_cmd_pkg::OP_FETCH,
                                         adc_cmd_pkg::MASK_NIBBLE_FREE);
   wire logic isRegRead = opByte & opMatch(rxByte, adc_cmd_pkg::OP_REG_READ,
                                           adc_cmd_pkg::MASK_NIBBLE_FREE);
   wire logic isRegWrite = opByte & opMatch(rxByte, adc_cmd_pkg::OP_REG_WRITE,
                                            adc_cmd_pkg::MASK_NIBBLE_FREE);
   wire logic wrLast = wrByte & (wrLeft_q == 2'h0);
   wire logic [1:0] opReg = rxByte[3:2];
   wire logic [2:0] opCount = {1'b0, rxByte[1:0]} + 3'h1;

   // buffer frozen while any byte or readout is under way
   wire logic frameBusy = active & ((bitCnt_q != '0) | (txBytes_q != '0));
   wire logic fifoValid;
   wire logic [RW-1:0] fifoData;
   wire logic bufLoad = fifoValid & ~frameBusy & ~isReset;
   wire logic autoLoad = active & sclkRise & (bitCnt_q == '0) & (txBytes_q == '0);
   wire logic [RW-1:0] txSource = bufLoad ? fifoData : resultBuf_q;

   logic [3:0][7:0] stageNext;
   always_comb begin
      stageNext = stage_q;
      stageNext[wrIdx_q] = rxByte;
   end

   // results queue here until the frame lets the buffer change
   adc_result_fifo #(
      .WIDTH(RW),
      .DEPTH(FIFO_DEPTH)
   ) resultFifo (
      .clk_sys(clk_sys),
      .rst(rst),
      .flush(isReset),
      .inValid(convResultValid),
      .inReady(convResultReady),
      .inData(convResult),
      .outValid(fifoValid),
      .outReady(~frameBusy),
      .outData(fifoData)
   );

   // ------------------------------------------------------------
   // receive framing and command decode
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         bitCnt_q <= '0;
         rxShift_q <= '0;
         dinHeld_q <= 1'b0;
      end else begin
         if (dinAgree) begin
            dinHeld_q <= dinBit;
         end
         if (!active) begin
            bitCnt_q <= '0;
         end else if (sclkFall) begin
            bitCnt_q <= bitCnt_q + 3'h1;
            rxShift_q <= rxByte;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= adc_cmd_pkg::CMD_OPCODE;
         cfgQ <= {adc_cmd_pkg::NUM_REGS{adc_cmd_pkg::CFG_RESET}};
         stage_q <= '0;
         wrIdx_q <= '0;
         wrLeft_q <= '0;
         sleep_q <= 1'b0;
         restart_q <= 1'b0;
         coreReset_q <= 1'b0;
      end else begin
         restart_q <= 1'b0;
         coreReset_q <= 1'b0;
         if (!active) begin
            state_q <= adc_cmd_pkg::CMD_OPCODE;
         end
         case (state_q)
            adc_cmd_pkg::CMD_OPCODE: begin
               if (isReset) begin
                  cfgQ <= {adc_cmd_pkg::NUM_REGS{adc_cmd_pkg::CFG_RESET}};
                  sleep_q <= 1'b0;
                  coreReset_q <= 1'b1;
               end else if (isKick) begin
                  restart_q <= 1'b1;
                  sleep_q <= 1'b0;
               end else if (isSleep) begin
                  sleep_q <= 1'b1;
               end else if (isRegWrite) begin
                  stage_q <= cfgQ;
                  wrIdx_q <= opReg;
                  wrLeft_q <= rxByte[1:0];
                  state_q <= adc_cmd_pkg::CMD_WDATA;
               end
               // any other byte falls through untouched
            end
            adc_cmd_pkg::CMD_WDATA: begin
               if (wrByte) begin
                  stage_q <= stageNext;
                  wrIdx_q <= wrIdx_q + 2'h1;
                  wrLeft_q <= wrLeft_q - 2'h1;
                  if (wrLast) begin
                     cfgQ <= stageNext;
                     restart_q <= 1'b1;
                     sleep_q <= 1'b0;
                     state_q <= adc_cmd_pkg::CMD_OPCODE;
                  end
               end
            end
            default: begin
               state_q <= adc_cmd_pkg::CMD_OPCODE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // transmit path and result buffer
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         txShift_q <= '0;
         txBytes_q <= '0;
         dataBit_q <= 1'b0;
         resultBuf_q <= '0;
      end else begin
         if (bufLoad) begin
            resultBuf_q <= fifoData;
         end
         if (isReset) begin
            resultBuf_q <= '0;
            txBytes_q <= '0;
         end else if (!active) begin
            txBytes_q <= '0;
         end else if (isFetch) begin
            txShift_q <= {resultBuf_q, 8'h00};
            txBytes_q <= adc_cmd_pkg::RESULT_BYTES;
         end else if (isRegRead) begin
            txShift_q <= regWindow(cfgQ, opReg);
            txBytes_q <= opCount;
         end else if (byteDone && txBytes_q != '0) begin
            txBytes_q <= txBytes_q - 3'h1;
         end else if (autoLoad) begin
            // direct readout with no command, MSB first
            dataBit_q <= txSource[RW-1];
            txShift_q <= {txSource[RW-2:0], 9'h000};
            txBytes_q <= adc_cmd_pkg::RESULT_BYTES;
         end else if (active && sclkRise) begin
            dataBit_q <= txShift_q[31];
            txShift_q <= {txShift_q[30:0], 1'b0};
         end
      end
   end

   // ------------------------------------------------------------
   // ready indication and pins
   // ------------------------------------------------------------
   wire logic readyOnPin = cfgQ[adc_cmd_pkg::REG_CURRENT_ROUTE][adc_cmd_pkg::READY_PIN_BIT];
   wire logic txIdle = (txBytes_q == '0) & (bitCnt_q == '0);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         readyN_q <= 1'b1;
         outEnN_q <= 1'b1;
         serialOut_q <= 1'b1;
      end else begin
         // a fresh result wins over the rising-edge release
         if (bufLoad) begin
            readyN_q <= 1'b0;
         end else if (sclkRise || isReset) begin
            readyN_q <= 1'b1;
         end
         outEnN_q <= ~active;
         serialOut_q <= (readyOnPin && txIdle) ? readyN_q : dataBit_q;
      end
   end

   // ------------------------------------------------------------
   // analog-facing settings
   // ------------------------------------------------------------
   wire logic [7:0] reg0 = cfgQ[adc_cmd_pkg::REG_INPUT_GAIN];
   wire logic [7:0] reg1 = cfgQ[adc_cmd_pkg::REG_RATE_MODE];
   wire logic [7:0] reg2 = cfgQ[adc_cmd_pkg::REG_REFERENCE_CURRENT];
   wire logic tempMode = reg1[adc_cmd_pkg::TEMP_SENSE_BIT];
   wire logic [3:0] selField = reg0[adc_cmd_pkg::SEL_HI:adc_cmd_pkg::SEL_LO];
   wire logic [2:0] gainField = reg0[adc_cmd_pkg::GAIN_HI:adc_cmd_pkg::GAIN_LO];

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         inSel_q <= '0;
         inAct_q <= 1'b0;
         gain_q <= adc_cmd_pkg::GAIN_UNITY;
         bypass_q <= 1'b0;
         contMode_q <= 1'b0;
         switch_q <= 1'b0;
         exc_q <= '0;
      end else begin
         inSel_q <= selField;
         inAct_q <= ~tempMode & ~sleep_q & (selField != adc_cmd_pkg::SEL_UNUSED);
         gain_q <= tempMode ? adc_cmd_pkg::GAIN_UNITY
                            : adc_cmd_pkg::GAIN_UNITY << gainField;
         bypass_q <= reg0[adc_cmd_pkg::BYPASS_BIT];
         contMode_q <= reg1[adc_cmd_pkg::CONV_MODE_BIT];
         switch_q <= reg2[adc_cmd_pkg::SWITCH_BIT] & ~sleep_q;
         exc_q <= sleep_q ? 3'h0 : reg2[adc_cmd_pkg::EXC_HI:adc_cmd_pkg::EXC_LO];
      end
   end

   assign serialOutWithReady = serialOut_q;
   assign serialOutEnN = outEnN_q;
   assign resultReadyN = readyN_q;
   assign convRestart = restart_q;
   assign coreReset = coreReset_q;
   assign sleepMode = sleep_q;
   assign cfgOut = adc_cmd_pkg::cfg_s'(cfgQ);
   assign inputSelect = inSel_q;
   assign inputActive = inAct_q;
   assign gainValue = gain_q;
   assign ampBypass = bypass_q;
   assign convContinuous = contMode_q;
   assign lowSideSwitchCtrl = switch_q;
   assign excitationSource = exc_q;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   AST_RESET_CLEARS: assert property (@(posedge clk_sys) disable iff (rst)
      isReset |=> (cfgQ == '0) && readyN_q && !sleep_q && coreReset_q)
      else $error("reset opcode did not restore defaults");
   AST_KICK_RESTARTS: assert property (@(posedge clk_sys) disable iff (rst)
      isKick |=> restart_q && !sleep_q ##1 !restart_q)
      else $error("kick opcode did not give one restart pulse");
   AST_SLEEP_ANALOG_OFF: assert property (@(posedge clk_sys) disable iff (rst)
      isSleep ##1 !isKick && !wrLast |=> sleep_q && exc_q == 3'h0 && !switch_q)
      else $error("sleep left analog parts powered");
   AST_FETCH_LOADS: assert property (@(posedge clk_sys) disable iff (rst)
      isFetch |=> txShift_q[31:8] == $past(resultBuf_q) && txBytes_q == adc_cmd_pkg::RESULT_BYTES)
      else $error("fetch did not load the current result");
   AST_WRITE_KEEPS_DATA: assert property (@(posedge clk_sys) disable iff (rst)
      wrByte |=> txShift_q == $past(txShift_q))
      else $error("register write disturbed outgoing data");
   AST_WRITE_COMMITS: assert property (@(posedge clk_sys) disable iff (rst)
      wrLast |=> restart_q && cfgQ == $past(stageNext))
      else $error("register write did not commit and restart");
   AST_READY_FALLS: assert property (@(posedge clk_sys) disable iff (rst)
      bufLoad |=> !readyN_q && resultBuf_q == $past(fifoData))
      else $error("new result did not pull ready low");
   AST_READY_RISES: assert property (@(posedge clk_sys) disable iff (rst)
      sclkRise && !bufLoad |=> readyN_q)
      else $error("ready stayed low after a rising serial edge");
   AST_BUFFER_FROZEN: assert property (@(posedge clk_sys) disable iff (rst)
      frameBusy && !isReset |=> $stable(resultBuf_q))
      else $error("result buffer changed inside a frame");
endmodule

`default_nettype wire

// file: hw/adc_cmd_pkg.sv
// Purpose: shared constants and types of the serial command decoder
// Assumes: one system clock; serial pins arrive asynchronous to it
// Notes: opcode patterns are value/mask pairs; mask bits set are compared
package adc_cmd_pkg;

   // ------------------------------------------------------------
   // opcodes
   // ------------------------------------------------------------
   localparam logic [7:0] OP_RESET = 8'h06;
   localparam logic [7:0] OP_KICK = 8'h08;
   localparam logic [7:0] OP_SLEEP = 8'h02;
   localparam logic [7:0] MASK_LSB_FREE = 8'hfe;
   localparam logic [7:0] OP_FETCH = 8'h10;
   localparam logic [7:0] OP_REG_READ = 8'h20;
   localparam logic [7:0] OP_REG_WRITE = 8'h40;
   localparam logic [7:0] MASK_NIBBLE_FREE = 8'hf0;

   // ------------------------------------------------------------
   // register map and fields
   // ------------------------------------------------------------
   localparam int NUM_REGS = 4;
   localparam logic [1:0] REG_INPUT_GAIN = 2'h0;
   localparam logic [1:0] REG_RATE_MODE = 2'h1;
   localparam logic [1:0] REG_REFERENCE_CURRENT = 2'h2;
   localparam logic [1:0] REG_CURRENT_ROUTE = 2'h3;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam int SEL_HI = 7;
   localparam int SEL_LO = 4;
   localparam int GAIN_HI = 3;
   localparam int GAIN_LO = 1;
   localparam int BYPASS_BIT = 0;
   localparam int CONV_MODE_BIT = 2;
   localparam int TEMP_SENSE_BIT = 1;
   localparam int SWITCH_BIT = 3;
   localparam int EXC_HI = 2;
   localparam int EXC_LO = 0;
   localparam int READY_PIN_BIT = 1;
   localparam logic [3:0] SEL_UNUSED = 4'hf;
   localparam logic [7:0] GAIN_UNITY = 8'h01;

   // ------------------------------------------------------------
   // serial framing
   // ------------------------------------------------------------
   localparam int RESULT_W = 24;
   localparam logic [2:0] RESULT_BYTES = 3'h3;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam int FIFO_DEPTH = 8;

   typedef struct packed {
      logic [7:0] currentRoute;
      logic [7:0] referenceCurrent;
      logic [7:0] rateMode;
      logic [7:0] inputGain;
   } cfg_s;

   typedef enum logic [1:0] {
      CMD_OPCODE = 2'b01,
      CMD_WDATA = 2'b10
   } cmd_state_e;

endpackage

// file: testbench/host_spi_model.sv
// Purpose: behavioural host serial controller
// Assumes: 100 ns serial period, serial clock idle low
// Notes: data pin sampled just before each falling edge
`timescale 1ns/1ps
`default_nettype none
module host_spi_model (
   // serial pins
   output logic serialClk,
   output logic chipSelectN,
   output logic serialIn,
   input wire logic dataPin
);
   initial begin
      serialClk = 1'b0;
      chipSelectN = 1'b1;
      serialIn = 1'b0;
   end
   task automatic sel(input logic v);
      chipSelectN = v;
      #100;
   endtask
   // data moves well clear of the fall so both sync chains agree
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         serialIn = tx[i];
         #35 serialClk = 1'b1;
         #50 rx[i] = dataPin;
         serialClk = 1'b0;
         #15;
      end
      serialIn = 1'b0;
   endtask
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// Purpose: self-checking bench of the serial command decoder
// Assumes: host model drives serial pins, bench plays converter core
// Notes: every frame is four bytes, padding bytes are zero
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
   $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
   logic clk_sys, rst, sclk, csN, din, dout, enN, readyN, cValid, cReady, pinLevel;
   logic cRestart, cReset, sleep, active, byp, cont, lsw;
   logic lastOut = 1'b0;
   logic [31:0] rx;
   logic [23:0] cWord, expWord;
   logic [7:0] b0, gain;
   logic [3:0] sel;
   logic [2:0] exc;
   adc_cmd_pkg::cfg_s cfg;
   int errors, tests_run, cycles, restarts, resets, n;
   // settings value beside the gain it should give; no single inputs here
   logic [15:0] rows [8] = '{16'h0001, 16'h1302, 16'h2404, 16'h3608,
      16'hc810, 16'hdb20, 16'hec40, 16'hff80};
   adc_serial_command_decoder #(.FIFO_DEPTH(8)) i_dut (.clk_sys(clk_sys), .rst(rst),
      .serialClk(sclk), .chipSelectN(csN), .serialIn(din), .serialOutWithReady(dout),
      .serialOutEnN(enN), .resultReadyN(readyN), .convResultValid(cValid),
      .convResultReady(cReady), .convResult(cWord), .convRestart(cRestart),
      .coreReset(cReset), .sleepMode(sleep), .cfgOut(cfg), .inputSelect(sel),
      .inputActive(active), .gainValue(gain), .ampBypass(byp), .convContinuous(cont),
      .lowSideSwitchCtrl(lsw), .excitationSource(exc));
   host_spi_model i_host (.serialClk(sclk), .chipSelectN(csN), .serialIn(din),
      .dataPin(pinLevel));
   // released pin shows the inverse of the last driven level, never a held copy
   assign pinLevel = enN ? ~lastOut : dout;
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      lastOut <= dout;
      if (cRestart === 1'b1) restarts++;
      if (cReset === 1'b1) resets++;
      cycles++;
      if (cycles == 20000) begin
         errors++;
         final_report();
      end
   end
   task automatic final_report();
      $display("tests_run=%0d errors=%0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic frame(input logic [31:0] tx);
      i_host.sel(1'b0);
      for (int k = 0; k < 4; k++) begin
         i_host.xfer(tx[31-8*k -: 8], b0);
         rx = {rx[23:0], b0};
      end
      i_host.sel(1'b1);
      repeat (4) @(posedge clk_sys);
      #1;
   endtask
   initial begin
      rst = 1'b1;
      cValid = 1'b0;
      cWord = 24'h0;
      repeat (2) @(posedge clk_sys);
      #1 rst = 1'b0;
      repeat (3) @(posedge clk_sys);
      `CHK(cfg, 32'h0)
      `CHK(readyN, 1'b1)
      $display("test reset done");
      foreach (rows[i]) begin
         frame({8'h40, rows[i][15:8], 8'h20, 8'h00});
         `CHK(rx[7:0], rows[i][15:8])
         `CHK(gain, rows[i][7:0])
         `CHK({sel, byp}, {rows[i][15:12], rows[i][8]})
         `CHK(active, rows[i][15:12] != 4'hf)
      end
      `CHK(restarts, 8)
      $display("test registers done");
      frame(32'h45040f00);
      frame(32'h03000000);
      `CHK({sleep, lsw, exc, cfg.referenceCurrent}, 13'h100f)
      n = restarts;
      frame(32'h09000000);
      `CHK({sleep, lsw, exc}, 5'h0f)
      `CHK(cont, 1'b1)
      frame(32'ha5000000);
      `CHK(cfg, 32'h000f04ff)
      `CHK(restarts, n + 1)
      frame(32'h07000000);
      `CHK({resets, cfg}, {32'h1, 32'h0})
      `CHK(cont, 1'b0)
      $display("test opcodes done");
      // an idle frame lets the buffer take each result at once
      cValid = 1'b1;
      cWord = 24'h5ac35a;
      @(posedge clk_sys);
      #1 cValid = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK(readyN, 1'b0)
      // newer results queue while the fetch frame holds the buffer
      fork
         frame(32'h10000000);
         begin
            #1000 cValid = 1'b1;
            for (n = 0; n < 12 && cReady === 1'b1; n++) begin
               cWord = {n[7:0], 16'hc35a};
               @(posedge clk_sys);
               #1;
            end
            cValid = 1'b0;
         end
      join
      `CHK(rx[23:0], 24'h5ac35a)
      `CHK(n, adc_cmd_pkg::FIFO_DEPTH)
      `CHK(readyN, 1'b0)
      expWord = 24'h07c35a;
      frame(32'h40350000);
      `CHK(rx[31:8], expWord)
      `CHK(cfg.inputGain, 8'h35)
      `CHK(readyN, 1'b1)
      frame(32'h0);
      `CHK(rx[31:8], expWord)
      frame(32'h10000000);
      `CHK(rx[23:0], expWord)
      `CHK(readyN, 1'b1)
      $display("test results done");
      final_report();
   end
endmodule
`default_nettype wire
